// File: design/sprc_pkg.sv
// Package with register map, field positions, modes and timing constants of the sleep/reset controller.
package sprc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SPRC_ADDR_SLEEP_CTRL  = 8'h00;
   localparam logic [7:0] SPRC_ADDR_CLK_GATE    = 8'h04;
   localparam logic [7:0] SPRC_ADDR_STATUS      = 8'h08;
   localparam logic [7:0] SPRC_ADDR_FUSES       = 8'h0C;

   localparam int SPRC_SLEEP_ALLOW_BIT = 5;
   localparam int SPRC_MODE_HI         = 4;
   localparam int SPRC_MODE_LO         = 3;
   localparam logic [7:0] SPRC_SLEEP_CTRL_WMASK = 8'h38;
   localparam logic [7:0] SPRC_SLEEP_CTRL_RST   = 8'h00;
   localparam logic [7:0] SPRC_CLK_GATE_RST     = 8'h00;

   // Clock-gate bit positions.
   localparam int SPRC_GATE_TWI    = 7;
   localparam int SPRC_GATE_USART1 = 6;
   localparam int SPRC_GATE_USART0 = 5;
   localparam int SPRC_GATE_SPI    = 4;
   localparam int SPRC_GATE_TIM2   = 3;
   localparam int SPRC_GATE_TIM1   = 2;
   localparam int SPRC_GATE_TIM0   = 1;
   localparam int SPRC_GATE_ADC    = 0;

   // Fuse register fields.
   localparam int SPRC_FUSE_ACT_LO   = 0;
   localparam int SPRC_FUSE_SLP_LO   = 2;
   localparam logic [3:0] SPRC_FUSE_RST = 4'hF;

   // ----------------------------------------------------------------
   // Encodings and types
   // ----------------------------------------------------------------
   localparam logic [1:0] SPRC_SM_IDLE    = 2'h0;
   localparam logic [1:0] SPRC_SM_ADCNR   = 2'h1;
   localparam logic [1:0] SPRC_SM_PWRDOWN = 2'h2;
   localparam logic [1:0] SPRC_SM_STANDBY = 2'h3;

   localparam logic [1:0] SPRC_BOD_RESERVED = 2'h0;
   localparam logic [1:0] SPRC_BOD_SAMPLED  = 2'h1;
   localparam logic [1:0] SPRC_BOD_ENABLED  = 2'h2;
   localparam logic [1:0] SPRC_BOD_DISABLED = 2'h3;

   typedef enum logic [2:0] {
      SPRC_ST_RESET,
      SPRC_ST_ACTIVE,
      SPRC_ST_SLEEP,
      SPRC_ST_WAKE
   } sprc_state_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SPRC_CLK_HZ        = 25_000_000;
   localparam int SPRC_TOUT_US       = 64;
   localparam int SPRC_TOUT_CYC      = (SPRC_TOUT_US * (SPRC_CLK_HZ / 1_000_000));
   localparam int SPRC_WAKE_STALL    = 4;
   localparam int SPRC_STANDBY_START = 6;
   localparam int SPRC_START_CYC     = 2;
   localparam int SPRC_WDT_PULSE     = 2;
   localparam int SPRC_CNT_W         = 16;
   localparam logic [15:0] SPRC_CNT_ONE = 16'h0001;

   // Clock enables toward the rest of the chip.
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic osc;
   } sprc_clk_en_t;

   // APB request from the master.
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sprc_apb_req_t;

   // APB answer to the master.
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sprc_apb_rsp_t;

endpackage : sprc_pkg

// File: design/sprc_top.sv
// Sleep control, peripheral clock gating, reset combining and brown-out mode control.
// ----------------------------------------------------------------
// Overview of operation
// [R1] Sleep instruction sleeps only while sleep-allow bit 5 is one.
// [R2] Mode bits 4:3 pick idle, ADC noise reduction, power-down or standby.
// [R3] Sleep-control bits 7:6 and 2 always read zero.
// [R4] Software sets sleep-allow just before sleep and clears it after waking.
// [R5] Input buffers off when I/O and ADC clocks stop, except wake pins.
// [R6] Clock-gate bit 7 stops the two-wire interface.
// [R7] Bits 6 and 5 stop second and first USART; clearing resumes unchanged.
// [R8] Bit 4 stops the SPI clock; software reinitialises SPI afterwards.
// [R9] Bits 3, 2, 1 freeze timers 2, 1, 0; clearing resumes them.
// [R10] Bit 0 stops the ADC and comparator; software disables ADC first.
// [R11] Reset loads initial register values; core restarts at reset vector.
// [R12] Port pins return to initial state at once on any reset source.
// [R13] After all sources release, a delay counter stretches internal reset.
// [R14] Internal reset combines power-on, pin, watchdog and brown-out sources.
// [R15] Power-on release starts the delay; its reassertion resets at once.
// [R16] Enabled reset pin low resets; restart after the time-out period.
// [R17] Watchdog makes a short pulse; delay starts on its falling edge.
// [R18] Enabled brown-out holds reset until the low-supply indication clears.
// [R19] Sampled mode powers detector only on falling edges of 1 kHz tick.
// [R20] Sampled detection switches to continuous until reset release and fuse read.
// [R21] Active fuse field sets detector mode in active and idle.
// [R22] Sleep fuse field sets detector mode in sleep modes beyond idle.
// [R23] Interrupt wake stalls the core four cycles beyond start-up time.
// [R24] Idle stops CPU and flash; ADC mode stops I/O; power-down stops all.
// [R25] Standby keeps the oscillator and wakes within six cycles.
// [R26] Gated peripherals stay frozen and their registers are inaccessible.
// [R27] Sleep with sleep-allow zero acts as a no-operation.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module sprc_top
   import sprc_pkg::*;
#(
   parameter int TOUT_CYC = SPRC_TOUT_CYC
)
(
   // Clock and asynchronous reset.
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   // APB slave.
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [7:0]    paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output logic               pready_o,
   output logic               pslverr_o,
   output logic [31:0]        prdata_o,
   // Core interface.
   input  wire logic          sleep_instr_i,
   input  wire logic          wake_irq_i,
   output logic               core_stall_o,
   output logic               core_reset_vec_o,
   // Reset sources, synchronous levels.
   input  wire logic          por_active_i,
   input  wire logic          ext_reset_n_i,
   input  wire logic          ext_reset_en_i,
   input  wire logic          wdt_timeout_i,
   input  wire logic          wdt_enabled_i,
   input  wire logic          bod_low_i,
   input  wire logic          tick_1khz_i,
   input  wire logic [3:0]    fuse_bits_i,
   // Outputs to the chip.
   output logic               int_reset_o,
   output logic               port_reset_o,
   output logic               bod_power_o,
   output logic               input_buf_en_o,
   output sprc_clk_en_t       clk_en_o,
   output logic [7:0]         periph_clk_stop_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      sprc_state_t     st;
      logic [7:0]      sleep_ctrl;
      logic [7:0]      clk_gate;
      logic [3:0]      fuses;
      logic [15:0]     cnt;
      logic [1:0]      wdt_cnt;
      logic            wdt_pulse;
      logic            bod_forced;
      logic            tick_prev;
      logic            bod_hit;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
      logic            int_reset;
      logic            port_reset;
      logic            bod_power;
      logic            input_buf_en;
      sprc_clk_en_t    clk_en;
      logic            stall;
      logic            reset_vec;
   } sprc_regs_t;

   sprc_regs_t q;
   sprc_regs_t d;

   // Every clock enable on, as in active operation.
   localparam sprc_clk_en_t CLK_ALL_ON = '{default: 1'b1};

   // Contents of the state while rst_n_i holds the block.
   localparam sprc_regs_t REGS_RST = '{
      st:           SPRC_ST_RESET,
      sleep_ctrl:   SPRC_SLEEP_CTRL_RST,
      clk_gate:     SPRC_CLK_GATE_RST,
      fuses:        SPRC_FUSE_RST,
      cnt:          16'(TOUT_CYC),
      int_reset:    1'b1,
      port_reset:   1'b1,
      input_buf_en: 1'b1,
      clk_en:       CLK_ALL_ON,
      stall:        1'b1,
      default:      '0
   };

   // Clock enables for a given sleep mode.
   function automatic sprc_clk_en_t mode_clocks(input logic [1:0] sm);
      sprc_clk_en_t c;
      c = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1, osc: 1'b1};
      unique case (sm)
         SPRC_SM_IDLE:    c = c;                                 // R24
         SPRC_SM_ADCNR:   c.io = 1'b0;                           // R24
         SPRC_SM_PWRDOWN: c = '{default: 1'b0};                  // R24
         SPRC_SM_STANDBY: c = '{cpu: 1'b0, flash: 1'b0, io: 1'b0,
                                adc: 1'b0, osc: 1'b1};           // R25
      endcase
      return c;
   endfunction : mode_clocks

   // Detector mode chosen by the fuse fields for the current state.
   function automatic logic [1:0] bod_mode(input logic [3:0] f, input logic sleeping,
                                           input logic [1:0] sm);
      logic [1:0] m;
      m = f[SPRC_FUSE_ACT_LO +: 2];                               // R21
      if (sleeping && (sm != SPRC_SM_IDLE))
      begin
         m = f[SPRC_FUSE_SLP_LO +: 2];                            // R22
      end
      return m;
   endfunction : bod_mode

   // Cycles from wake-up until the core runs, start-up plus the stall.
   function automatic logic [15:0] wake_cycles(input logic [1:0] sm);
      logic [15:0] n;
      n = 16'(SPRC_START_CYC + SPRC_WAKE_STALL) - SPRC_CNT_ONE;        // R23
      if (sm == SPRC_SM_STANDBY)
      begin
         n = 16'(SPRC_STANDBY_START + SPRC_WAKE_STALL) - SPRC_CNT_ONE; // R25
      end
      return n;
   endfunction : wake_cycles

   // True for an offset that holds a register.
   function automatic logic reg_known(input logic [7:0] a);
      return (a == SPRC_ADDR_SLEEP_CTRL) || (a == SPRC_ADDR_CLK_GATE)
             || (a == SPRC_ADDR_STATUS) || (a == SPRC_ADDR_FUSES);
   endfunction : reg_known

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic       src_active;
   logic       bod_en;
   logic       bod_trip;
   logic [1:0] eff_mode;
   logic       sleeping;
   logic       tick_fall;
   logic       setup_wr;
   logic       setup_rd;
   logic       bus_acc;

   always_comb
   begin
      d = q;
      sleeping  = (q.st == SPRC_ST_SLEEP);
      tick_fall = q.tick_prev && !tick_1khz_i;
      eff_mode  = bod_mode(q.fuses, sleeping, q.sleep_ctrl[SPRC_MODE_HI:SPRC_MODE_LO]);
      if (q.bod_forced)
      begin
         eff_mode = SPRC_BOD_ENABLED;                              // R20
      end
      bod_en   = (eff_mode == SPRC_BOD_ENABLED) || (eff_mode == SPRC_BOD_SAMPLED);
      // Continuous mode trips at once; sampled mode only on the tick's falling edge.
      bod_trip = bod_low_i && ((eff_mode == SPRC_BOD_ENABLED)
                 || ((eff_mode == SPRC_BOD_SAMPLED) && tick_fall));   // R19 R18
      d.tick_prev = tick_1khz_i;
      d.bod_power = (eff_mode == SPRC_BOD_ENABLED)
                    || ((eff_mode == SPRC_BOD_SAMPLED) && tick_fall); // R19
      if (bod_trip && (eff_mode == SPRC_BOD_SAMPLED))
      begin
         d.bod_forced = 1'b1;                                      // R20
      end
      d.bod_hit = bod_trip || (q.bod_hit && bod_en && bod_low_i);  // R18

      // Watchdog expiry becomes a short pulse.
      if (wdt_timeout_i && wdt_enabled_i && (q.wdt_cnt == '0))
      begin
         d.wdt_cnt = 2'(SPRC_WDT_PULSE);                           // R17
      end
      else if (q.wdt_cnt != '0)
      begin
         d.wdt_cnt = q.wdt_cnt - 2'h1;
      end
      d.wdt_pulse = (d.wdt_cnt != '0);

      src_active = por_active_i                                    // R14 R15
                   || (ext_reset_en_i && !ext_reset_n_i)           // R16
                   || d.wdt_pulse                                  // R17
                   || bod_trip || q.bod_hit;                       // R18


      // ----------------------------------------------------------------
      // Register bus: the slave answers one cycle after the access phase opens.
      // ----------------------------------------------------------------
      setup_rd  = psel_i && penable_i && !q.pready && !pwrite_i;
      setup_wr  = psel_i && penable_i && !q.pready && pwrite_i;
      bus_acc   = psel_i && penable_i && q.pready;
      d.pready  = setup_rd || setup_wr;
      d.pslverr = (setup_rd || setup_wr) && !reg_known(paddr_i);
      d.prdata  = '0;
      if (setup_rd)
      begin
         case (paddr_i)
            SPRC_ADDR_SLEEP_CTRL: d.prdata = 32'(q.sleep_ctrl & SPRC_SLEEP_CTRL_WMASK); // R3
            SPRC_ADDR_CLK_GATE:   d.prdata = 32'(q.clk_gate);
            SPRC_ADDR_STATUS:     d.prdata = 32'({q.bod_forced, q.bod_hit});
            SPRC_ADDR_FUSES:      d.prdata = 32'(q.fuses);
            default:              d.prdata = '0;
         endcase
      end
      // A write lands at the completing edge; the internal reset keeps it out.
      if (bus_acc && pwrite_i && !q.int_reset)
      begin
         if (paddr_i == SPRC_ADDR_SLEEP_CTRL)
         begin
            d.sleep_ctrl = pwdata_i[7:0] & SPRC_SLEEP_CTRL_WMASK;      // R1 R2 R3
         end
         if (paddr_i == SPRC_ADDR_CLK_GATE)
         begin
            d.clk_gate = pwdata_i[7:0];                                // R6 R7 R8 R9 R10
         end
      end

      // ----------------------------------------------------------------
      // Sleep and wake sequence
      // ----------------------------------------------------------------
      unique case (q.st)
         SPRC_ST_RESET:
         begin
            d.stall = 1'b1;
         end
         SPRC_ST_ACTIVE:
         begin
            // Without the allow bit a sleep instruction changes nothing.
            if (sleep_instr_i && q.sleep_ctrl[SPRC_SLEEP_ALLOW_BIT])   // R1 R27
            begin
               d.st     = SPRC_ST_SLEEP;
               d.stall  = 1'b1;
               d.clk_en = mode_clocks(q.sleep_ctrl[SPRC_MODE_HI:SPRC_MODE_LO]); // R2
            end
         end
         SPRC_ST_SLEEP:
         begin
            if (wake_irq_i)
            begin
               d.st     = SPRC_ST_WAKE;
               d.clk_en = CLK_ALL_ON;
               d.cnt    = wake_cycles(q.sleep_ctrl[SPRC_MODE_HI:SPRC_MODE_LO]); // R23 R25
            end
         end
         SPRC_ST_WAKE:
         begin
            if (q.cnt != '0)
            begin
               d.cnt = q.cnt - SPRC_CNT_ONE;                            // R23
            end
            else
            begin
               d.st    = SPRC_ST_ACTIVE;
               d.stall = 1'b0;
            end
         end
         default:
         begin
            d.st = SPRC_ST_RESET;
         end
      endcase

      // ----------------------------------------------------------------
      // Reset combining and stretching
      // ----------------------------------------------------------------
      d.reset_vec = 1'b0;
      if (src_active)
      begin
         // Any active source resets at once and reloads the delay.
         d.int_reset  = 1'b1;                                           // R14 R15
         d.cnt        = 16'(TOUT_CYC);                                  // R13
         d.st         = SPRC_ST_RESET;
         d.stall      = 1'b1;
         d.sleep_ctrl = SPRC_SLEEP_CTRL_RST;                            // R11
         d.clk_gate   = SPRC_CLK_GATE_RST;                              // R11
         d.clk_en     = CLK_ALL_ON;
      end
      else if (q.int_reset && (q.cnt != '0))
      begin
         d.cnt = q.cnt - SPRC_CNT_ONE;                                  // R13 R16 R17
      end
      else if (q.int_reset)
      begin
         // Release: the fuses are read in again and the core starts at its vector.
         d.int_reset  = 1'b0;
         d.st         = SPRC_ST_ACTIVE;
         d.stall      = 1'b0;
         d.reset_vec  = 1'b1;                                           // R11
         d.fuses      = fuse_bits_i;                                    // R21 R22
         d.bod_forced = 1'b0;                                           // R20
      end
      d.port_reset   = d.int_reset;                                     // R12
      d.input_buf_en = d.clk_en.io || d.clk_en.adc;                     // R5
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= REGS_RST;                                                 // R11
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pready_o          = q.pready;
   assign pslverr_o         = q.pslverr;
   assign prdata_o          = q.prdata;
   assign core_stall_o      = q.stall;                                  // R23
   assign core_reset_vec_o  = q.reset_vec;                              // R11
   assign int_reset_o       = q.int_reset;                              // R13
   assign port_reset_o      = q.port_reset;                             // R12
   assign bod_power_o       = q.bod_power;                              // R19
   assign input_buf_en_o    = q.input_buf_en;                           // R5
   assign clk_en_o          = q.clk_en;                                 // R24
   assign periph_clk_stop_o = q.clk_gate;                               // R26

endmodule : sprc_top

// File: tb/sprc_core_model.sv
// Core model that issues sleep instructions and wake interrupts.
`timescale 1ns/10ps
module sprc_core_model
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Bench requests and controller stall.
   input  wire logic sleep_req_i,
   input  wire logic wake_req_i,
   input  wire logic core_stall_i,
   // Toward the controller.
   output logic      sleep_instr_o,
   output logic      wake_irq_o
);
   // A stalled core executes nothing, so no sleep instruction leaves it.
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         sleep_instr_o <= 1'b0;
         wake_irq_o    <= 1'b0;
      end
      else
      begin
         sleep_instr_o <= sleep_req_i && !core_stall_i;
         wake_irq_o    <= wake_req_i;
      end
endmodule : sprc_core_model

// File: tb/sprc_top_sva.sv
// Checker of the sleep and reset controller ports.
`timescale 1ns/10ps
module sprc_top_sva
   import sprc_pkg::*;
#(
   parameter int TOUT_CYC = 20
)
(
   input wire logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic sleep_instr_i, por_active_i, ext_reset_n_i, ext_reset_en_i,
   input wire logic wdt_timeout_i, bod_low_i, int_reset_o, port_reset_o, input_buf_en_o,
   input wire logic [3:0] fuse_bits_i,
   input sprc_clk_en_t clk_en_o,
   input wire logic [7:0] periph_clk_stop_o
);
   // ----------------------------------------------------------------
   // Helper state and assertions
   // ----------------------------------------------------------------
   logic acc, src, se_q;
   int   quiet_q;
   assign acc = psel_i && penable_i && pready_o;
   assign src = por_active_i || (ext_reset_en_i && !ext_reset_n_i) || wdt_timeout_i || bod_low_i;
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         se_q    <= 1'b0;
         quiet_q <= 0;
      end
      else
      begin
         if (acc && pwrite_i && paddr_i == SPRC_ADDR_SLEEP_CTRL)
            se_q <= pwdata_i[SPRC_SLEEP_ALLOW_BIT];
         quiet_q <= (int_reset_o && !src) ? quiet_q + 1 : 0;
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_reserved_zero: assert property (acc && !pwrite_i && paddr_i == SPRC_ADDR_SLEEP_CTRL
      |-> prdata_o[7:6] == 2'h0 && !prdata_o[2]) else $error("reserved bits not zero");
   chk_gate_follow: assert property (acc && pwrite_i && paddr_i == SPRC_ADDR_CLK_GATE
      |=> periph_clk_stop_o == $past(pwdata_i[7:0])) else $error("clock stop mismatch");
   chk_sleep_noop: assert property (sleep_instr_i && !se_q && clk_en_o.cpu
      |=> clk_en_o.cpu [*3]) else $error("slept without allow bit");
   chk_por_now: assert property (por_active_i |=> int_reset_o && port_reset_o)
      else $error("power-on reset late");
   chk_pin_now: assert property (ext_reset_en_i && !ext_reset_n_i |=> port_reset_o)
      else $error("pin reset late");
   chk_stretch_min: assert property ($fell(por_active_i) |-> int_reset_o [*8])
      else $error("reset not stretched");
   chk_stretch_max: assert property (quiet_q <= TOUT_CYC + 8)
      else $error("reset stretched too long");
   chk_buf_off: assert property (!clk_en_o.io && !clk_en_o.adc |-> !input_buf_en_o)
      else $error("input buffers on in deep sleep");
   chk_bod_reset: assert property (bod_low_i && fuse_bits_i[1:0] == SPRC_BOD_ENABLED
      && clk_en_o.cpu |-> ##[0:8] int_reset_o) else $error("brown-out ignored");
   cov_sleep: cover property (!clk_en_o.cpu);
   cov_release: cover property ($fell(int_reset_o));
   cov_gate: cover property (periph_clk_stop_o == 8'h80);
endmodule : sprc_top_sva
bind sprc_top sprc_top_sva #(.TOUT_CYC(TOUT_CYC)) i_sva (.clk_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .pready_o, .paddr_i, .pwdata_i, .prdata_o, .sleep_instr_i, .por_active_i,
   .ext_reset_n_i, .ext_reset_en_i, .wdt_timeout_i, .bod_low_i, .int_reset_o, .port_reset_o,
   .input_buf_en_o, .fuse_bits_i, .clk_en_o, .periph_clk_stop_o);

// File: tb/tb_sprc_top.sv
// Self-checking testbench of the sleep and reset controller.
`timescale 1ns/10ps
module tb_sprc_top
   import sprc_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals, clock and instances
   // ----------------------------------------------------------------
   localparam int TB_TOUT = 20;
   logic clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, por_active_i = 0;
   logic ext_reset_n_i = 1, ext_reset_en_i = 1, wdt_timeout_i = 0, wdt_enabled_i = 1;
   logic bod_low_i = 0, tick_1khz_i = 0, sleep_req = 0, wake_req = 0, sleep_instr_i, wake_irq_i;
   logic pready_o, pslverr_o, core_stall_o, core_reset_vec_o, int_reset_o, port_reset_o;
   logic bod_power_o, input_buf_en_o, err;
   logic [7:0] paddr_i = 8'h00, periph_clk_stop_o;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [3:0] fuse_bits_i = 4'hA;
   sprc_clk_en_t clk_en_o;
   int mismatches = 0, total_checks = 0;
   always #20 clk_i = ~clk_i;
   always begin repeat (50) @(posedge clk_i); tick_1khz_i <= ~tick_1khz_i; end
   sprc_top #(.TOUT_CYC(TB_TOUT)) i_sprc_top (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .sleep_instr_i, .wake_irq_i,
      .core_stall_o, .core_reset_vec_o, .por_active_i, .ext_reset_n_i, .ext_reset_en_i,
      .wdt_timeout_i, .wdt_enabled_i, .bod_low_i, .tick_1khz_i, .fuse_bits_i, .int_reset_o,
      .port_reset_o, .bod_power_o, .input_buf_en_o, .clk_en_o, .periph_clk_stop_o);
   sprc_core_model i_sprc_core_model (.clk_i, .rst_n_i, .sleep_req_i(sleep_req),
      .wake_req_i(wake_req), .core_stall_i(core_stall_o), .sleep_instr_o(sleep_instr_i),
      .wake_irq_o(wake_irq_i));
   // ----------------------------------------------------------------
   // Tasks and scenarios
   // ----------------------------------------------------------------
   task conclude;
      if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         mismatches++;
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      psel_i <= 1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      n = 0;
      do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) begin mismatches++; conclude(); end
      r = prdata_o; err = pslverr_o;
      psel_i <= 0; penable_i <= 0;
      @(posedge clk_i);
   endtask : apb
   task t_regs;
      apb(0, SPRC_ADDR_SLEEP_CTRL, 0, rd); chk("sleep_ctrl_reset", 32'h0, rd);
      apb(1, SPRC_ADDR_SLEEP_CTRL, 32'hFF, rd);
      apb(0, SPRC_ADDR_SLEEP_CTRL, 0, rd); chk("sleep_ctrl_reserved", 32'h38, rd);
      for (int b = 0; b < 8; b++)
      begin
         apb(1, SPRC_ADDR_CLK_GATE, 32'h1 << b, rd);
         @(posedge clk_i); chk("clk_stop", 32'h1 << b, {24'h0, periph_clk_stop_o});
      end
      apb(1, SPRC_ADDR_CLK_GATE, 0, rd); apb(0, 8'h3C, 0, rd);
      chk("bad_addr_err", 32'h1, {31'h0, err});
      apb(1, SPRC_ADDR_SLEEP_CTRL, 0, rd);
   endtask : t_regs
   task t_sleep(input logic [1:0] m, input logic se);
      int n;
      apb(1, SPRC_ADDR_SLEEP_CTRL, {26'h0, se, m, 3'h0}, rd);
      sleep_req <= 1; @(posedge clk_i); sleep_req <= 0; repeat (4) @(posedge clk_i);
      chk("clocks", {28'h0, !se, !se || m == 0, !se || m != 2, !se || m < 2}, {28'h0,
         clk_en_o.cpu, clk_en_o.io, clk_en_o.osc, input_buf_en_o});
      wake_req <= 1; n = 0; @(posedge clk_i);
      while ((core_stall_o !== 1'b0 || clk_en_o.cpu !== 1'b1) && n < 60) begin @(posedge clk_i); n++; end
      if (n >= 60) begin mismatches++; conclude(); end
      wake_req <= 0; apb(1, SPRC_ADDR_SLEEP_CTRL, 0, rd);
   endtask : t_sleep
   task t_rst(input int s);
      int n;
      if (s == 0) por_active_i <= 1; else if (s == 1) ext_reset_n_i <= 0;
      else if (s == 2) bod_low_i <= 1; else wdt_timeout_i <= 1;
      repeat (s == 2 ? 12 : 2) @(posedge clk_i);
      chk("reset_on", 32'h3, {30'h0, int_reset_o, port_reset_o});
      por_active_i <= 0; ext_reset_n_i <= 1; bod_low_i <= 0; wdt_timeout_i <= 0; n = 0;
      while (int_reset_o !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
      chk("stretch", 32'h1, {31'h0, n >= TB_TOUT - 2 && n < TB_TOUT + 8});
   endtask : t_rst
   task t_bodm(input logic [3:0] f, input int lo, input int hi);
      int c;
      fuse_bits_i <= f; t_rst(0); c = 0;
      repeat (200) begin @(posedge clk_i); c += bod_power_o; end
      chk("bod_power", 32'h1, {31'h0, c >= lo && c <= hi});
   endtask : t_bodm
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1;
      @(posedge clk_i);
      t_rst(0); t_regs();
      for (int m = 0; m < 4; m++) t_sleep(m[1:0], 1'b1);
      t_sleep(SPRC_SM_PWRDOWN, 1'b0);
      t_rst(1); t_rst(2); t_rst(3);
      t_bodm(4'h5, 1, 20); t_bodm(4'hF, 0, 0); t_bodm(4'hA, 200, 200);
      conclude();
   end
endmodule : tb_sprc_top
